// ### src/srg_match_if.sv
`timescale 1ns/10ps
interface srg_match_if;
  logic [srg_pkg::PHYS_W-1:0] addr;
  logic [63:0] vbase;
  logic [63:0] vmask;
  logic hit;
  logic [7:0] mtype;
  modport req (output addr, output vbase, output vmask, input hit, input mtype);
  modport rsp (input addr, input vbase, input vmask, output hit, output mtype);
endinterface

// ### src/srg_pkg.sv
package srg_pkg;
  // register selectors on the model-register port
  localparam logic [1:0] SEL_BASE = 2'h0;
  localparam logic [1:0] SEL_MASK = 2'h1;
  localparam logic [1:0] SEL_VBASE = 2'h2;
  localparam logic [1:0] SEL_VMASK = 2'h3;
  // field positions
  localparam int TYPE_LSB = 0;
  localparam int TYPE_MSB = 7;
  localparam int ADDR_LSB = 12;
  localparam int SMR_ADDR_MSB = 31;
  localparam int VALID_BIT = 11;
  localparam int CAP_BIT = 11;
  localparam int VAR_FIELD_W = 24;
  localparam int PHYS_W = 36;
  // memory types
  localparam logic [7:0] MT_UC = 8'h00;
  localparam logic [7:0] MT_WC = 8'h01;
  localparam logic [7:0] MT_WB = 8'h06;
  // blocked read value per byte
  localparam logic [7:0] BLOCK_BYTE = 8'hFF;
  // reserved-bit masks (1 = writable)
  localparam logic [63:0] SMR_BASE_WMASK = 64'h0000_0000_FFFF_F0FF;
  localparam logic [63:0] SMR_MASK_WMASK = 64'h0000_0000_FFFF_F800;
  localparam logic [63:0] VAR_BASE_WMASK = 64'h0000_000F_FFFF_F0FF;
  localparam logic [63:0] VAR_MASK_WMASK = 64'h0000_000F_FFFF_F800;
  localparam logic [63:0] REG_RESET = 64'h0000_0000_0000_0000;
endpackage

// ### src/srg_range_guard.sv
// Operation
// - capability register bit 11 reports the protected range feature.
// - base and mask writes only in management mode, else protection fault.
// - base register bits 0-7 hold management-mode memory type.
// - base from bits 12-31, low twelve bits zero.
// - mask from bits 12-31, extended with twelve low zero bits.
// - inside when address and mask equals base and mask.
// - mask bit 11 enables the range check.
// - feature absent: every base or mask access faults.
// - optionally require feature-control enable before any base or mask access.
// - in management mode, protected hits use base register type.
// - outside management mode: writes dropped, reads fixed, uncached.
// - protected range wins over variable range types.
// - variable base and mask are 24-bit fields widened to 36 bits.
// - nonzero reserved bits in variable registers fault on write.
`timescale 1ns/10ps
module srg_range_guard
  import srg_pkg::*;
#(
  parameter logic CAP_PRESENT = 1'b1,
  parameter logic NEED_FEAT_EN = 1'b0,
  parameter int DATA_BYTES = 8
) (
  // clock, reset, enable
  input wire logic clk_sys_i,
  input wire logic nrst_i,
  input wire logic ce_i,
  // core state
  input wire logic mgmt_mode_i,
  input wire logic feat_en_i,
  // model-register port
  input wire logic reg_rd_i,
  input wire logic reg_wr_i,
  input wire logic [1:0] reg_sel_i,
  input wire logic [63:0] reg_wdata_i,
  output logic [63:0] reg_rdata_o,
  output logic reg_fault_o,
  output logic [63:0] cap_o,
  // memory access check
  input wire logic acc_valid_i,
  input wire logic acc_write_i,
  input wire logic [PHYS_W-1:0] acc_addr_i,
  output logic acc_pass_o,
  output logic acc_block_o,
  output logic [7:0] acc_type_o,
  output logic [DATA_BYTES*8-1:0] acc_fill_o
);
  localparam logic [63:0] CAP_WORD = 64'(CAP_PRESENT) << CAP_BIT;

  // elaboration-time parameter checks
  if (DATA_BYTES < 1 || DATA_BYTES > 8) begin : g_bad_bytes
    $error("srg: DATA_BYTES out of range");
  end
  if (SMR_ADDR_MSB >= PHYS_W || ADDR_LSB + VAR_FIELD_W != PHYS_W) begin : g_bad_fields
    $error("srg: address fields do not fit the physical width");
  end
  if (CAP_BIT > 63 || VALID_BIT > 63 || TYPE_MSB >= ADDR_LSB) begin : g_bad_bits
    $error("srg: flag positions outside the 64-bit registers");
  end

  typedef enum logic [1:0] {
    SRG_IDLE = 2'b01,
    SRG_RESP = 2'b10
  } srg_state_e;

  srg_state_e st_q, st_d;
  logic [63:0] base_q, base_d, mask_q, mask_d, vbase_q, vbase_d, vmask_q, vmask_d;
  logic [63:0] rdata_q, rdata_d;
  logic fault_q, fault_d;
  logic pass_q, pass_d, block_q, block_d;
  logic [7:0] type_q, type_d;
  logic [DATA_BYTES*8-1:0] fill_q, fill_d;
  logic smr_ok, smr_hit, is_smr;
  logic [63:0] cap_q, cap_d;
  logic [PHYS_W-1:0] smr_base, smr_mask;

  srg_match_if mif();
  assign mif.addr = acc_addr_i;
  assign mif.vbase = vbase_q;
  assign mif.vmask = vmask_q;
  srg_var_match u_var (.m(mif));

  function automatic logic rsvd_bad(input logic [63:0] v, input logic [63:0] wm);
    rsvd_bad = |(v & ~wm);
  endfunction

  // upper mask bits stay set so the range never reaches past 4 GBytes
  function automatic logic [PHYS_W-1:0] smr_field(input logic [63:0] r, input logic hi);
    smr_field = {{(PHYS_W-SMR_ADDR_MSB-1){hi}}, r[SMR_ADDR_MSB:ADDR_LSB], {ADDR_LSB{1'b0}}};
  endfunction

  function automatic logic in_range(input logic [PHYS_W-1:0] a, input logic [PHYS_W-1:0] b,
    input logic [PHYS_W-1:0] m);
    in_range = ((a & m) == (b & m));
  endfunction

  assign smr_ok = CAP_PRESENT && (!NEED_FEAT_EN || feat_en_i);
  assign is_smr = (reg_sel_i == SEL_BASE) || (reg_sel_i == SEL_MASK);
  assign smr_base = smr_field(base_q, 1'b0);
  assign smr_mask = smr_field(mask_q, 1'b1);
  assign smr_hit = mask_q[VALID_BIT] && in_range(acc_addr_i, smr_base, smr_mask);

  always_comb begin
    st_d = st_q;
    base_d = base_q;
    mask_d = mask_q;
    vbase_d = vbase_q;
    vmask_d = vmask_q;
    rdata_d = rdata_q;
    fault_d = 1'b0;
    case (st_q)
      SRG_IDLE: begin
        if (reg_wr_i) begin
          st_d = SRG_RESP;
          if (is_smr && (!smr_ok || !mgmt_mode_i)) begin
            fault_d = 1'b1;
          end else if (reg_sel_i == SEL_BASE) begin
            if (rsvd_bad(reg_wdata_i, SMR_BASE_WMASK)) fault_d = 1'b1;
            else base_d = reg_wdata_i;
          end else if (reg_sel_i == SEL_MASK) begin
            if (rsvd_bad(reg_wdata_i, SMR_MASK_WMASK)) fault_d = 1'b1;
            else mask_d = reg_wdata_i;
          end else if (reg_sel_i == SEL_VBASE) begin
            if (rsvd_bad(reg_wdata_i, VAR_BASE_WMASK)) fault_d = 1'b1;
            else vbase_d = reg_wdata_i;
          end else begin
            if (rsvd_bad(reg_wdata_i, VAR_MASK_WMASK)) fault_d = 1'b1;
            else vmask_d = reg_wdata_i;
          end
        end else if (reg_rd_i) begin
          st_d = SRG_RESP;
          if (is_smr && !smr_ok) begin
            fault_d = 1'b1;
            rdata_d = REG_RESET;
          end else begin
            case (reg_sel_i)
              SEL_BASE: rdata_d = base_q;
              SEL_MASK: rdata_d = mask_q;
              SEL_VBASE: rdata_d = vbase_q;
              default: rdata_d = vmask_q;
            endcase
          end
        end
      end
      SRG_RESP: st_d = SRG_IDLE;
      default: st_d = SRG_IDLE;
    endcase
  end

  always_comb begin
    pass_d = 1'b0;
    block_d = 1'b0;
    type_d = MT_UC;
    fill_d = '0;
    if (acc_valid_i) begin
      if (smr_ok && smr_hit) begin
        if (mgmt_mode_i) begin
          pass_d = 1'b1;
          type_d = base_q[TYPE_MSB:TYPE_LSB];
        end else begin
          block_d = 1'b1;
          type_d = MT_UC;
          if (!acc_write_i) fill_d = {DATA_BYTES{BLOCK_BYTE}};
        end
      end else begin
        pass_d = 1'b1;
        // single variable range; its type on a hit, uncached on a miss
        type_d = mif.hit ? mif.mtype : MT_UC;
      end
    end
  end

  always_ff @(posedge clk_sys_i) begin
    if (!nrst_i) begin
      st_q <= SRG_IDLE;
      base_q <= REG_RESET;
      mask_q <= REG_RESET;
      vbase_q <= REG_RESET;
      vmask_q <= REG_RESET;
      rdata_q <= REG_RESET;
      fault_q <= 1'b0;
      pass_q <= 1'b0;
      block_q <= 1'b0;
      type_q <= MT_UC;
      fill_q <= '0;
    end else if (ce_i) begin
      st_q <= st_d;
      base_q <= base_d;
      mask_q <= mask_d;
      vbase_q <= vbase_d;
      vmask_q <= vmask_d;
      rdata_q <= rdata_d;
      fault_q <= fault_d;
      pass_q <= pass_d;
      block_q <= block_d;
      type_q <= type_d;
      fill_q <= fill_d;
    end
  end

  always_comb begin
    cap_d = CAP_WORD;
  end

  always_ff @(posedge clk_sys_i) begin
    if (!nrst_i) begin
      cap_q <= CAP_WORD;
    end else if (ce_i) begin
      cap_q <= cap_d;
    end
  end

  assign cap_o = cap_q;
  assign reg_rdata_o = rdata_q;
  assign reg_fault_o = fault_q;
  assign acc_pass_o = pass_q;
  assign acc_block_o = block_q;
  assign acc_type_o = type_q;
  assign acc_fill_o = fill_q;
endmodule // srg_range_guard

// ### src/srg_var_match.sv
`timescale 1ns/10ps
module srg_var_match
  import srg_pkg::*;
(
  srg_match_if.rsp m
);
  logic [VAR_FIELD_W-1:0] b_f;
  logic [VAR_FIELD_W-1:0] m_f;
  logic [PHYS_W-1:0] b_full;
  logic [PHYS_W-1:0] m_full;
  always_comb begin
    // 24-bit fields widened to 36-bit addresses
    b_f = m.vbase[ADDR_LSB +: VAR_FIELD_W];
    m_f = m.vmask[ADDR_LSB +: VAR_FIELD_W];
    b_full = {b_f, {ADDR_LSB{1'b0}}};
    m_full = {m_f, {ADDR_LSB{1'b0}}};
    m.hit = m.vmask[VALID_BIT] && ((m.addr & m_full) == (b_full & m_full));
    m.mtype = m.vbase[TYPE_MSB:TYPE_LSB];
  end
endmodule // srg_var_match

// ### test/srg_core_model.sv
`timescale 1ns/10ps
module srg_core_model (
  // commands, access out
  input wire logic clk_i,
  input wire logic go_i,
  input wire logic wr_i,
  input wire logic [35:0] addr_i,
  output logic valid_o,
  output logic write_o,
  output logic [35:0] addr_o
);
  initial begin
    valid_o = 1'h0;
    write_o = 1'h0;
    addr_o = 36'h0;
  end
  // idle address toggles
  always @(posedge clk_i) begin
    valid_o <= go_i;
    write_o <= wr_i;
    addr_o <= go_i ? addr_i : ~addr_o;
  end
endmodule // srg_core_model

// ### test/srg_range_guard_assertions.sv
`timescale 1ns/10ps
module srg_range_guard_assertions
  import srg_pkg::*;
(
  // clock, reset
  input wire logic clk_sys_i,
  input wire logic nrst_i,
  // inputs
  input wire logic mgmt_mode_i,
  input wire logic reg_wr_i,
  input wire logic [1:0] reg_sel_i,
  input wire logic [63:0] reg_wdata_i,
  input wire logic acc_valid_i,
  input wire logic acc_write_i,
  // outputs
  input wire logic reg_fault_o,
  input wire logic [63:0] cap_o,
  input wire logic acc_pass_o,
  input wire logic acc_block_o,
  input wire logic [7:0] acc_type_o,
  input wire logic [63:0] acc_fill_o
);
  default clocking cb @(posedge clk_sys_i); endclocking
  default disable iff (!nrst_i);
  a_cap_bit: assert property (cap_o[CAP_BIT]) else $error("capability bit clear");
  a_wr_outside: assert property (reg_wr_i && !mgmt_mode_i && reg_sel_i < 2'h2 |=> reg_fault_o)
    else $error("write outside mode not faulted");
  a_resv_fault: assert property (reg_wr_i && reg_sel_i == SEL_VBASE && |(reg_wdata_i & ~VAR_BASE_WMASK) |=> reg_fault_o)
    else $error("reserved bit write not faulted");
  a_block_uc: assert property (acc_block_o |-> acc_type_o == MT_UC) else $error("blocked not uncached");
  a_block_mode: assert property (acc_block_o |-> !$past(mgmt_mode_i) && $past(acc_valid_i))
    else $error("block in management mode");
  a_pass_excl: assert property ($past(acc_valid_i) |-> acc_pass_o != acc_block_o) else $error("pass and block clash");
  a_fill_ff: assert property (acc_block_o && !$past(acc_write_i) |-> acc_fill_o == {8{BLOCK_BYTE}})
    else $error("blocked read fill wrong");
  a_fill_zero: assert property (!acc_block_o |-> acc_fill_o == 64'h0) else $error("fill without block");
  c_block: cover property (acc_block_o);
  c_fault: cover property (reg_fault_o);
  c_pass_wb: cover property (acc_pass_o && acc_type_o == MT_WB);
endmodule // srg_range_guard_assertions
bind srg_range_guard srg_range_guard_assertions srg_range_guard_assertions_i (.clk_sys_i(clk_sys_i),
  .nrst_i(nrst_i), .mgmt_mode_i(mgmt_mode_i), .reg_wr_i(reg_wr_i), .reg_sel_i(reg_sel_i),
  .reg_wdata_i(reg_wdata_i), .acc_valid_i(acc_valid_i), .acc_write_i(acc_write_i), .reg_fault_o(reg_fault_o),
  .cap_o(cap_o), .acc_pass_o(acc_pass_o), .acc_block_o(acc_block_o), .acc_type_o(acc_type_o),
  .acc_fill_o(acc_fill_o));

// ### test/srg_range_guard_tb_top.sv
`timescale 1ns/10ps
module srg_range_guard_tb_top;
  import srg_pkg::*;
  typedef struct packed {logic m; logic w; logic [35:0] a; logic b; logic [7:0] t;} srg_row_s;
  logic clk_sys_i, nrst_i, ce_i, mgmt_mode_i, feat_en_i, reg_rd_i, reg_wr_i, go, cw;
  logic acc_valid_i, acc_write_i, reg_fault_o, acc_pass_o, acc_block_o;
  logic [1:0] reg_sel_i;
  logic [63:0] reg_wdata_i, reg_rdata_o, cap_o, acc_fill_o;
  logic [35:0] ca, acc_addr_i;
  logic [7:0] acc_type_o;
  int checks_done, miscompares;
  srg_row_s rows[6] = '{'{1'h1, 1'h0, 36'h0_0010_0040, 1'h0, MT_WC}, '{1'h0, 1'h0, 36'h0_0010_0040, 1'h1, MT_UC},
    '{1'h0, 1'h1, 36'h0_001F_FFF8, 1'h1, MT_UC}, '{1'h0, 1'h0, 36'h0_0030_0000, 1'h0, MT_WB},
    '{1'h0, 1'h0, 36'h0_0040_0000, 1'h0, MT_UC}, '{1'h0, 1'h0, 36'h1_0010_0040, 1'h0, MT_UC}};
  srg_range_guard #(.NEED_FEAT_EN(1'h1)) srg_range_guard_i (.clk_sys_i(clk_sys_i), .nrst_i(nrst_i), .ce_i(ce_i),
    .mgmt_mode_i(mgmt_mode_i), .feat_en_i(feat_en_i), .reg_rd_i(reg_rd_i), .reg_wr_i(reg_wr_i),
    .reg_sel_i(reg_sel_i), .reg_wdata_i(reg_wdata_i), .reg_rdata_o(reg_rdata_o), .reg_fault_o(reg_fault_o),
    .cap_o(cap_o), .acc_valid_i(acc_valid_i), .acc_write_i(acc_write_i), .acc_addr_i(acc_addr_i),
    .acc_pass_o(acc_pass_o), .acc_block_o(acc_block_o), .acc_type_o(acc_type_o), .acc_fill_o(acc_fill_o));
  srg_core_model srg_core_model_i (.clk_i(clk_sys_i), .go_i(go), .wr_i(cw), .addr_i(ca),
    .valid_o(acc_valid_i), .write_o(acc_write_i), .addr_o(acc_addr_i));
  task automatic chk(input string n, input logic [63:0] seen, input logic [63:0] exp);
    checks_done++;
    if (seen !== exp) begin
      miscompares++;
      $display("[FAIL] %s expected %h seen %h", n, exp, seen);
    end
  endtask
  task automatic rop(input logic m, input logic w, input logic [1:0] s, input logic [63:0] d, input logic f);
    @(posedge clk_sys_i);
    mgmt_mode_i <= m;
    reg_wr_i <= w;
    reg_rd_i <= !w;
    reg_sel_i <= s;
    reg_wdata_i <= d;
    @(posedge clk_sys_i);
    reg_wr_i <= 1'h0;
    reg_rd_i <= 1'h0;
    #1 chk("fault", reg_fault_o, f);
    @(posedge clk_sys_i);
  endtask
  task automatic acc(input srg_row_s r);
    @(posedge clk_sys_i);
    mgmt_mode_i <= r.m;
    go <= 1'h1;
    cw <= r.w;
    ca <= r.a;
    @(posedge clk_sys_i);
    go <= 1'h0;
    @(posedge clk_sys_i);
    #1 chk("block", acc_block_o, r.b);
    chk("pass", acc_pass_o, !r.b);
    chk("type", acc_type_o, r.t);
    chk("fill", acc_fill_o, (r.b && !r.w) ? {8{BLOCK_BYTE}} : 64'h0);
  endtask
  task automatic end_of_test;
    $display("checks %0d miscompares %0d", checks_done, miscompares);
    if (miscompares == 0 && checks_done > 0) $display("Result: passed");
    else $display("Result: failed");
    $finish;
  endtask
  initial begin
    clk_sys_i = 1'h0;
    forever #10 clk_sys_i = ~clk_sys_i;
  end
  initial begin
    #100us miscompares++;
    end_of_test;
  end
  initial begin
    {nrst_i, mgmt_mode_i, feat_en_i, reg_rd_i, reg_wr_i, go, cw, reg_sel_i} = '0;
    ce_i = 1'h1;
    reg_wdata_i = 64'h0;
    ca = 36'h0;
    repeat (2) @(posedge clk_sys_i);
    nrst_i <= 1'h1;
    rop(1'h1, 1'h0, SEL_BASE, 64'h0, 1'h1);
    feat_en_i <= 1'h1;
    rop(1'h1, 1'h0, SEL_BASE, 64'h0, 1'h0);
    chk("reset", reg_rdata_o, REG_RESET);
    chk("cap", cap_o[CAP_BIT], 1'h1);
    rop(1'h1, 1'h1, SEL_BASE, 64'h0010_0001, 1'h0);
    rop(1'h1, 1'h1, SEL_MASK, 64'hFFF0_0800, 1'h0);
    rop(1'h1, 1'h1, SEL_VBASE, 64'h6, 1'h0);
    rop(1'h1, 1'h1, SEL_VMASK, 64'hF_FFC0_0800, 1'h0);
    foreach (rows[i]) acc(rows[i]);
    rop(1'h0, 1'h1, SEL_BASE, 64'h0020_0006, 1'h1);
    rop(1'h1, 1'h0, SEL_BASE, 64'h0, 1'h0);
    chk("base", reg_rdata_o, 64'h0010_0001);
    // clock enable low: the write is not taken
    ce_i <= 1'h0;
    rop(1'h1, 1'h1, SEL_BASE, 64'h0020_0006, 1'h0);
    ce_i <= 1'h1;
    rop(1'h1, 1'h0, SEL_BASE, 64'h0, 1'h0);
    chk("ce_hold", reg_rdata_o, 64'h0010_0001);
    rop(1'h1, 1'h1, SEL_VBASE, 64'h106, 1'h1);
    rop(1'h1, 1'h1, SEL_MASK, 64'hFFF0_0000, 1'h0);
    acc('{1'h0, 1'h0, 36'h0_0010_0040, 1'h0, MT_WB});
    // reset in mid-run clears both range pairs
    @(posedge clk_sys_i);
    nrst_i <= 1'h0;
    repeat (2) @(posedge clk_sys_i);
    nrst_i <= 1'h1;
    rop(1'h1, 1'h0, SEL_MASK, 64'h0, 1'h0);
    chk("mask_rst", reg_rdata_o, REG_RESET);
    chk("cap_rst", cap_o[CAP_BIT], 1'h1);
    acc('{1'h0, 1'h0, 36'h0_0010_0040, 1'h0, MT_UC});
    end_of_test;
  end
endmodule // srg_range_guard_tb_top
